/* hw/spi_flags.v */
// flag, interrupt and register bank of the byte-wide serial peripheral controller
//
// The plain strobed port and the address map were left to the implementer.
`include "spi_flags_map.vh"

// ==========================================
// Summary of operation
// - as slave without written byte, shift out last received byte
// - data reads return zero after reset until a byte is received
// - interrupt request only while module enable is set
// - receive/fault enable gates receive-full and mode-fault flags
// - transmit enable gates transmit-empty flag
// - match enable gates data-match flag
// - one interrupt line: any flag together with its enable
// - flags set and stay readable with masks clear
// - mode fault aborts transfer and clears master select
// - mode-fault interrupt is a level while the flag stands
// - receive-full sets when a received byte enters the buffer
// - receive-full holds; bytes arriving while set are discarded
// - transmit-empty sets when buffer can take a byte, holds until serviced
// - data-match sets when receive buffer equals match value
// - control one bit layout, enables down to lsb-first
// - control two layout with match enable, fault enable, bidir bits
// - baud: bit 7 reserved, 6:4 prescale, 3:0 rate divisor
// - status: rx full, match, tx empty, fault; low nibble zero
// - polarity and phase bits exported to the shift engine
// - lsb-first and fault-detect enable exported as configuration
// - data address: write loads transmit, read returns receive buffer
// - fault clears on status read seeing it, then control one write
module spi_flags (
  input wire CLK, // bus clock, 100 MHz
  input wire RSTN, // asynchronous reset, active low
  input wire [2:0] ADDR, // register index
  input wire [7:0] WDATA, // write data
  input wire WR, // write strobe
  input wire RD, // read strobe
  output reg [7:0] RDATA, // read data, one cycle after RD
  input wire RX_DONE, // pulse: shift engine finished a byte
  input wire [7:0] RX_BYTE, // byte received with RX_DONE
  input wire TX_TAKE, // pulse: shift engine took the transmit byte
  input wire SS_N, // slave-select input, active low
  output reg [7:0] TX_BYTE, // byte for the shift engine to send
  output wire TX_PENDING, // a written byte waits for the shift engine
  output wire ABORT, // pulse: transfer aborted by mode fault
  output wire IRQ, // interrupt request, active high level
  output wire MODULE_ENABLE, // control one module enable
  output wire MASTER_SELECT, // control one master select
  output wire CLOCK_POLARITY, // control one clock polarity
  output wire CLOCK_PHASE, // control one clock phase
  output wire SELECT_OUTPUT_ENABLE, // control one select output enable
  output wire LSB_FIRST, // control one lsb-first
  output wire FAULT_DETECT_ENABLE, // control two fault detect enable
  output wire BIDIR_OUTPUT_ENABLE, // control two bidir output enable
  output wire STOP_IN_WAIT, // control two stop-in-wait
  output wire SINGLE_PIN_SELECT, // control two single-pin select
  output wire [2:0] PRESCALE, // baud prescale select
  output wire [3:0] RATE // baud rate select
);

  reg [7:0] c1_q;
  reg [7:0] c2_q;
  reg [7:0] br_q;
  reg [7:0] match_q;
  reg [7:0] rxbuf_q;
  reg rx_full_q;
  reg tx_empty_q;
  reg fault_q;
  reg match_flag_q;
  reg seen_rx_q;
  reg seen_tx_q;
  reg seen_fault_q;
  reg ss_q;

  wire wr_c1 = WR && (ADDR == `OFS_CONTROL_ONE);
  wire wr_c2 = WR && (ADDR == `OFS_CONTROL_TWO);
  wire wr_br = WR && (ADDR == `OFS_BAUD_DIVIDER);
  wire wr_m = WR && (ADDR == `OFS_MATCH_COMPARE);
  wire wr_d = WR && (ADDR == `OFS_SHIFT_DATA);
  wire rd_s = RD && (ADDR == `OFS_FLAG_STATUS);
  wire rd_d = RD && (ADDR == `OFS_SHIFT_DATA);

  // ==========================================
  // mode fault detection
  // fault only counts for a master with detect on and select output off
  wire fault_set = c1_q[`C1_MODULE_ENABLE] && c1_q[`C1_MASTER_SELECT] && c2_q[`C2_FAULT_DETECT_ENABLE] &&
                   !c1_q[`C1_SELECT_OUTPUT_ENABLE] && !SS_N && !ss_q;
  wire fault_clr = seen_fault_q && wr_c1;
  assign ABORT = fault_set && !fault_q;

  // bytes landing while receive-full stands are dropped
  wire rx_load = RX_DONE && !rx_full_q;
  wire rx_clr = seen_rx_q && rd_d;
  wire tx_clr = seen_tx_q && wr_d;

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      c1_q <= `RST_CONTROL_ONE;
      c2_q <= `RST_CONTROL_TWO;
      br_q <= `RST_BAUD_DIVIDER;
      match_q <= `RST_MATCH_COMPARE;
      rxbuf_q <= `RST_DATA;
      TX_BYTE <= `RST_DATA;
      ss_q <= 1'b1;
      rx_full_q <= 1'b0;
      tx_empty_q <= 1'b1;
      fault_q <= 1'b0;
      match_flag_q <= 1'b0;
      seen_rx_q <= 1'b0;
      seen_tx_q <= 1'b0;
      seen_fault_q <= 1'b0;
    end else begin
      ss_q <= SS_N;
      if (wr_c1) begin
        c1_q <= WDATA;
      end
      if (fault_set || fault_q) begin
        c1_q[`C1_MASTER_SELECT] <= 1'b0;
      end
      if (wr_c2) begin
        c2_q <= WDATA & `C2_WRITE_MASK;
      end
      if (wr_br) begin
        br_q <= WDATA & `BR_WRITE_MASK;
      end
      if (wr_m) begin
        match_q <= WDATA;
      end
      if (wr_d) begin
        TX_BYTE <= WDATA;
      end else if (rx_load && tx_empty_q) begin
        TX_BYTE <= RX_BYTE;
      end
      if (rx_load) begin
        rxbuf_q <= RX_BYTE;
      end
      // set wins over clear on every flag
      if (rx_load) begin
        rx_full_q <= 1'b1;
      end else if (rx_clr) begin
        rx_full_q <= 1'b0;
      end
      if (TX_TAKE) begin
        tx_empty_q <= 1'b1;
      end else if (tx_clr) begin
        tx_empty_q <= 1'b0;
      end
      if (fault_set) begin
        fault_q <= 1'b1;
      end else if (fault_clr) begin
        fault_q <= 1'b0;
      end
      match_flag_q <= (rxbuf_q == match_q) && (rx_full_q || match_flag_q && !rx_load);
      if (rd_s) begin
        seen_rx_q <= rx_full_q;
        seen_tx_q <= tx_empty_q;
        seen_fault_q <= fault_q;
      end else begin
        if (rx_clr) seen_rx_q <= 1'b0;
        if (tx_clr) seen_tx_q <= 1'b0;
        if (fault_clr) seen_fault_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // read port
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `OFS_CONTROL_ONE: RDATA <= c1_q;
        `OFS_CONTROL_TWO: RDATA <= c2_q;
        `OFS_BAUD_DIVIDER: RDATA <= br_q;
        `OFS_FLAG_STATUS: RDATA <= {rx_full_q, match_flag_q, tx_empty_q, fault_q, 4'h0};
        `OFS_SHIFT_DATA: RDATA <= rxbuf_q;
        `OFS_MATCH_COMPARE: RDATA <= match_q;
        default: RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ==========================================
  // interrupt request
  wire irq_rx = c1_q[`C1_RX_FAULT_IRQ_ENABLE] && (rx_full_q || fault_q);
  wire irq_tx = c1_q[`C1_TX_IRQ_ENABLE] && tx_empty_q;
  wire irq_m = c2_q[`C2_MATCH_IRQ_ENABLE] && match_flag_q;
  assign IRQ = c1_q[`C1_MODULE_ENABLE] && (irq_rx || irq_tx || irq_m);

  assign TX_PENDING = !tx_empty_q;
  assign MODULE_ENABLE = c1_q[`C1_MODULE_ENABLE];
  assign MASTER_SELECT = c1_q[`C1_MASTER_SELECT];
  assign CLOCK_POLARITY = c1_q[`C1_CLOCK_POLARITY];
  assign CLOCK_PHASE = c1_q[`C1_CLOCK_PHASE];
  assign SELECT_OUTPUT_ENABLE = c1_q[`C1_SELECT_OUTPUT_ENABLE];
  assign LSB_FIRST = c1_q[`C1_LSB_FIRST];
  assign FAULT_DETECT_ENABLE = c2_q[`C2_FAULT_DETECT_ENABLE];
  assign BIDIR_OUTPUT_ENABLE = c2_q[`C2_BIDIR_OUTPUT_ENABLE];
  assign STOP_IN_WAIT = c2_q[`C2_STOP_IN_WAIT];
  assign SINGLE_PIN_SELECT = c2_q[`C2_SINGLE_PIN_SELECT];
  assign PRESCALE = br_q[6:4];
  assign RATE = br_q[3:0];

endmodule

/* hw/spi_flags_map.vh */
// register offsets, field positions and reset values of the serial flag block
`ifndef SPI_FLAGS_MAP_VH
`define SPI_FLAGS_MAP_VH
// ==========================================
// register offsets
`define OFS_CONTROL_ONE 3'h0
`define OFS_CONTROL_TWO 3'h1
`define OFS_BAUD_DIVIDER 3'h2
`define OFS_FLAG_STATUS 3'h3
`define OFS_MATCH_COMPARE 3'h5
`define OFS_SHIFT_DATA 3'h4
// ==========================================
// control_one fields
`define C1_RX_FAULT_IRQ_ENABLE 7
`define C1_MODULE_ENABLE 6
`define C1_TX_IRQ_ENABLE 5
`define C1_MASTER_SELECT 4
`define C1_CLOCK_POLARITY 3
`define C1_CLOCK_PHASE 2
`define C1_SELECT_OUTPUT_ENABLE 1
`define C1_LSB_FIRST 0
// ==========================================
// control_two fields
`define C2_MATCH_IRQ_ENABLE 7
`define C2_FAULT_DETECT_ENABLE 4
`define C2_BIDIR_OUTPUT_ENABLE 3
`define C2_STOP_IN_WAIT 1
`define C2_SINGLE_PIN_SELECT 0
`define C2_WRITE_MASK 8'h9b
// ==========================================
// baud_divider and status fields
`define BR_WRITE_MASK 8'h7f
`define ST_RX_FULL 7
`define ST_DATA_MATCH 6
`define ST_TX_EMPTY 5
`define ST_FAULT 4
// ==========================================
// reset values
`define RST_CONTROL_ONE 8'h04
`define RST_CONTROL_TWO 8'h00
`define RST_BAUD_DIVIDER 8'h00
`define RST_MATCH_COMPARE 8'h00
`define RST_DATA 8'h00
`endif

/* testbench/spi_flags_sva.sv */
// port-level assertion checker for the serial flag block
module spi_flags_sva (
  input wire CLK,
  input wire RSTN,
  input wire [2:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  input wire TX_TAKE,
  input wire SS_N,
  input wire TX_PENDING,
  input wire ABORT,
  input wire IRQ,
  input wire MODULE_ENABLE,
  input wire MASTER_SELECT,
  input wire [3:0] RATE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // ==========================================
  // assertions
  a_irq_off: assert property (!MODULE_ENABLE |-> !IRQ) else $error("irq while disabled");
  a_abort_cause: assert property (ABORT |-> !SS_N && MASTER_SELECT && MODULE_ENABLE) else $error("bad abort");
  a_abort_master: assert property (ABORT |=> !MASTER_SELECT) else $error("master kept");
  a_take_empty: assert property (TX_TAKE |=> !TX_PENDING) else $error("take not seen");
  a_rd_idle: assert property (!RD |=> RDATA == 8'h00) else $error("stray read data");
  a_status_low: assert property (RD && ADDR == 3'h3 |=> RDATA[3:0] == 4'h0) else $error("status low");
  a_unmapped_zero: assert property (RD && ADDR > 3'h5 |=> RDATA == 8'h00) else $error("unmapped");
  a_enable_write: assert property (WR && ADDR == 3'h0 |=> MODULE_ENABLE == $past(WDATA[6])) else $error("c1");
  a_rate_write: assert property (WR && ADDR == 3'h2 |=> RATE == $past(WDATA[3:0])) else $error("rate");
  c_abort: cover property (ABORT);
  c_irq: cover property (IRQ);
  c_take: cover property (TX_TAKE);
endmodule

bind spi_flags spi_flags_sva spi_flags_sva_inst (.CLK, .RSTN, .ADDR, .WDATA, .WR, .RD, .RDATA, .TX_TAKE,
  .SS_N, .TX_PENDING, .ABORT, .IRQ, .MODULE_ENABLE, .MASTER_SELECT, .RATE);

/* testbench/engine_model.sv */
// stand-in for the shift engine and the external select line
module engine_model (
  input wire CLK, // bus clock
  input wire TX_PENDING, // byte waits to go
  output logic RX_DONE = 1'b0, // byte finished
  output logic [7:0] RX_BYTE = 8'h00, // received byte
  output logic TX_TAKE = 1'b0, // byte taken
  output logic SS_N = 1'b1 // select, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  task xfer(input logic [7:0] b);
    @(posedge CLK);
    RX_DONE <= 1'b1;
    RX_BYTE <= b;
    TX_TAKE <= TX_PENDING;
    @(posedge CLK);
    RX_DONE <= 1'b0;
    TX_TAKE <= 1'b0;
    // inverse after the pulse so a stale byte cannot pass
    RX_BYTE <= ~b;
  endtask
  task fault();
    @(posedge CLK);
    SS_N <= 1'b0;
    repeat (3) @(posedge CLK);
    SS_N <= 1'b1;
  endtask
endmodule

/* testbench/tb_top.sv */
// self-checking bench of the serial flag block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0, RSTN = 0, WR = 0, RD = 0, rd_pend = 0;
  logic [2:0] ADDR = 0;
  logic [7:0] WDATA = 0, RDATA, TX_BYTE, RX_BYTE, m, r;
  logic RX_DONE, TX_TAKE, SS_N, TX_PENDING, ABORT, IRQ, MODULE_ENABLE, MASTER_SELECT, CLOCK_POLARITY, CLOCK_PHASE;
  logic SELECT_OUTPUT_ENABLE, LSB_FIRST, FAULT_DETECT_ENABLE, BIDIR_OUTPUT_ENABLE, STOP_IN_WAIT, SINGLE_PIN_SELECT;
  logic [2:0] PRESCALE;
  logic [3:0] RATE;
  logic [15:0] exp_q[$];
  logic [7:0] rstv [8] = '{8'h04, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [16:0] tbl [5] = '{{8'h40, 8'h00, 1'b0}, {8'h60, 8'h00, 1'b1}, {8'h20, 8'h00, 1'b0}, {8'hc0, 8'h00, 1'b0},
    {8'h40, 8'h80, 1'b1}};
  int mismatches = 0, checks_done = 0, seed = 58, i;
  spi_flags spi_flags_inst (.CLK, .RSTN, .ADDR, .WDATA, .WR, .RD, .RDATA, .RX_DONE, .RX_BYTE, .TX_TAKE, .SS_N,
    .TX_BYTE, .TX_PENDING, .ABORT, .IRQ, .MODULE_ENABLE, .MASTER_SELECT, .CLOCK_POLARITY, .CLOCK_PHASE,
    .SELECT_OUTPUT_ENABLE, .LSB_FIRST, .FAULT_DETECT_ENABLE, .BIDIR_OUTPUT_ENABLE, .STOP_IN_WAIT,
    .SINGLE_PIN_SELECT, .PRESCALE, .RATE);
  engine_model engine_model_inst (.CLK, .TX_PENDING, .RX_DONE, .RX_BYTE, .TX_TAKE, .SS_N);
  initial begin
    forever #5 CLK = ~CLK;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    #1;
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================
  // bus master: strobes stay up until idle, so no signal is driven twice in one step
  task wr(input logic [2:0] a, input logic [7:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    RD <= 1'b0;
    @(posedge CLK);
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] k = 8'hff);
    ADDR <= a;
    RD <= 1'b1;
    WR <= 1'b0;
    exp_q.push_back({k, e & k});
    @(posedge CLK);
  endtask
  task idle(input int n);
    WR <= 1'b0;
    RD <= 1'b0;
    repeat (n) @(posedge CLK);
  endtask
  task rx(input logic [7:0] b);
    idle(0);
    engine_model_inst.xfer(b);
    idle(2);
  endtask
  // ==========================================
  // read data monitor
  always @(posedge CLK) rd_pend <= RD;
  // take the note off the queue before comparing, so argument order cannot matter
  always @(negedge CLK) begin : rd_mon
    logic [15:0] note;
    if (rd_pend) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("[ERR] %0t got %h exp %h", $time, RDATA, 8'h00);
      end else begin
        note = exp_q.pop_front();
        chk(RDATA & note[15:8], note[7:0]);
      end
    end
  end
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
  initial begin
    m = $random(seed);
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    for (i = 0; i < 8; i++) rd(i[2:0], rstv[i]);
    wr(3'h1, 8'hff);
    wr(3'h2, 8'hff);
    rd(3'h1, 8'h9b);
    rd(3'h2, 8'h7f);
    r = $random(seed);
    wr(3'h0, r);
    rd(3'h0, r);
    chk({2'b0, MODULE_ENABLE, MASTER_SELECT, CLOCK_POLARITY, CLOCK_PHASE, SELECT_OUTPUT_ENABLE, LSB_FIRST},
      {2'b0, r[6], r[4:0]});
    chk({4'h0, FAULT_DETECT_ENABLE, BIDIR_OUTPUT_ENABLE, STOP_IN_WAIT, SINGLE_PIN_SELECT}, 8'h0f);
    chk({1'b0, PRESCALE, RATE}, 8'h7f);
    $display("test layout done");
    wr(3'h0, 8'h40);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h5, m);
    rx(m);
    rd(3'h3, 8'he0);
    chk(TX_BYTE, m);
    chk({7'h0, IRQ}, 8'h00);
    rx(~m);
    rd(3'h4, m);
    rd(3'h3, 8'h60);
    $display("test receive done");
    for (i = 0; i < 5; i++) begin
      wr(3'h0, tbl[i][16:9]);
      wr(3'h1, tbl[i][8:1]);
      idle(1);
      chk({7'h0, IRQ}, {7'h0, tbl[i][0]});
    end
    wr(3'h1, 8'h00);
    wr(3'h0, 8'hc0);
    rx(~m);
    chk({7'h0, IRQ}, 8'h01);
    rd(3'h3, 8'ha0);
    rd(3'h4, ~m);
    r = $random(seed);
    rd(3'h3, 8'h20);
    wr(3'h4, r);
    idle(1);
    chk({7'h0, TX_PENDING}, 8'h01);
    chk(TX_BYTE, r);
    rx(m);
    chk({7'h0, TX_PENDING}, 8'h00);
    rd(3'h3, 8'he0);
    rd(3'h4, m);
    $display("test irq and transmit done");
    wr(3'h1, 8'h10);
    wr(3'h0, 8'hd0);
    idle(0);
    engine_model_inst.fault();
    chk({7'h0, MASTER_SELECT}, 8'h00);
    chk({7'h0, IRQ}, 8'h01);
    rd(3'h3, 8'h10, 8'h10);
    wr(3'h0, 8'hc0);
    idle(1);
    chk({7'h0, IRQ}, 8'h00);
    $display("test fault done");
    idle(2);
    end_sim();
  end
endmodule
